// ---- design/scr_top.sv ----
// Switching configuration register bank with rate, thresholds, sync mode and trip limit
`timescale 1ns/10ps
`default_nettype none
module scr_top (
  input wire logic sys_clk,
  input wire logic rst,
  input wire scr_pkg::scr_req_t req,
  input wire logic err_clr,
  input wire logic [10:0] rate_strap_khz,
  input wire logic [10:0] vin_half_volts,
  input wire logic [15:0] vout_sense,
  input wire logic vdd_ok_pin,
  input wire logic rate_sync_in,
  output logic [15:0] rd_data,
  output logic rd_ack,
  output logic cmd_err,
  output logic bank_ready,
  output logic conv_en,
  output logic ov_fault,
  output logic switch_pulse,
  output logic rate_sync_out,
  output logic rate_sync_oe
);
  scr_pkg::scr_state_t state_r;
  logic [15:0] rate_r;
  logic [15:0] start_r;
  logic [15:0] stop_r;
  logic [15:0] mode_r;
  logic [15:0] ov_r;
  logic override_r;
  logic [10:0] strap_r;
  logic [15:0] rd_data_r;
  logic rd_ack_r;
  logic cmd_err_r;
  logic conv_en_r;
  logic ov_fault_r;
  logic sync_out_r;
  logic sync_oe_r;
  logic sync_s1_r;
  logic sync_s2_r;
  logic sync_d_r;
  logic vdd_s1_r;
  logic vdd_s2_r;
  logic serving;
  logic wr_take;
  logic rd_take;
  logic wr_bad;
  logic ext_edge;
  logic mode_source;
  logic mode_follow;
  logic [10:0] freq_eff;
  logic gen_pulse;
  logic ready_r;
  logic wr_rate;
  logic wr_start;
  logic wr_stop;
  logic wr_mode;
  logic wr_ov;
  logic code_known;
  logic rd_bad;

  // Request qualifiers and sync mode decode
  assign serving = (state_r == scr_pkg::ST_SERVE);
  assign wr_take = serving && req.wr;
  assign rd_take = serving && req.rd && !req.wr;
  assign mode_source = (mode_r == scr_pkg::MODE_SOURCE);
  assign mode_follow = (mode_r == scr_pkg::MODE_INPHASE) || (mode_r == scr_pkg::MODE_ANTI);

  // One enable per target; a refused write enables nothing
  assign wr_rate = wr_take && !wr_bad && (req.code == scr_pkg::CODE_RATE);
  assign wr_start = wr_take && !wr_bad && (req.code == scr_pkg::CODE_START);
  assign wr_stop = wr_take && !wr_bad && (req.code == scr_pkg::CODE_STOP);
  assign wr_mode = wr_take && !wr_bad && (req.code == scr_pkg::CODE_MODE);
  assign wr_ov = wr_take && !wr_bad && (req.code == scr_pkg::CODE_OV);

  // Mapped codes; a read of anything else is answered with zero and flagged
  always_comb begin
    unique case (req.code)
      scr_pkg::CODE_RATE, scr_pkg::CODE_START, scr_pkg::CODE_STOP: code_known = 1'b1;
      scr_pkg::CODE_MODE, scr_pkg::CODE_OV, scr_pkg::CODE_STATUS: code_known = 1'b1;
      default: code_known = 1'b0;
    endcase
  end

  assign rd_bad = rd_take && !code_known; // RL20

  // Bank stays deaf for one cycle after reset while defaults are copied in
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= scr_pkg::ST_LOAD;
    end else begin
      unique case (state_r)
        scr_pkg::ST_LOAD: begin
          state_r <= scr_pkg::ST_SERVE; // RL21
        end
        scr_pkg::ST_SERVE: begin
          state_r <= scr_pkg::ST_SERVE;
        end
        default: begin
          state_r <= scr_pkg::ST_LOAD;
        end
      endcase
    end
  end

  // Ready is a flop of its own so the port never shows a state decode
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ready_r <= 1'b0;
    end else begin
      ready_r <= (state_r == scr_pkg::ST_LOAD) || serving; // RL21
    end
  end

  // Write check per target; unknown codes are refused as well
  always_comb begin
    wr_bad = 1'b0;
    if (wr_take) begin
      unique case (req.code)
        scr_pkg::CODE_RATE: wr_bad = !scr_pkg::rate_ok(req.data); // RL3 RL4 RL18
        scr_pkg::CODE_START: wr_bad = !scr_pkg::volt_ok(req.data); // RL7 RL8
        scr_pkg::CODE_STOP: wr_bad = !scr_pkg::volt_ok(req.data); // RL10
        scr_pkg::CODE_MODE: wr_bad = !scr_pkg::mode_ok(req.data); // RL16
        scr_pkg::CODE_OV: wr_bad = 1'b0;
        default: wr_bad = 1'b1;
      endcase
    end
  end

  // Switching-rate word; a refused write leaves it as it was
  always_ff @(posedge sys_clk) begin
    if (rst || state_r == scr_pkg::ST_LOAD) begin
      rate_r <= scr_pkg::DEF_RATE; // RL5 RL21
    end else if (wr_rate) begin
      rate_r <= req.data; // RL1 RL20
    end
  end

  // Start threshold in half volts under exponent minus one
  always_ff @(posedge sys_clk) begin
    if (rst || state_r == scr_pkg::ST_LOAD) begin
      start_r <= scr_pkg::DEF_START; // RL8
    end else if (wr_start) begin
      start_r <= req.data; // RL6
    end
  end

  // Stop threshold, same format and range as the start threshold
  always_ff @(posedge sys_clk) begin
    if (rst || state_r == scr_pkg::ST_LOAD) begin
      stop_r <= scr_pkg::DEF_STOP; // RL10
    end else if (wr_stop) begin
      stop_r <= req.data; // RL9
    end
  end

  // Sync mode word, only the four defined codes ever stored
  always_ff @(posedge sys_clk) begin
    if (rst || state_r == scr_pkg::ST_LOAD) begin
      mode_r <= scr_pkg::DEF_MODE; // RL16
    end else if (wr_mode) begin
      mode_r <= req.data; // RL11
    end
  end

  // Overvoltage trip is plain unsigned, so every value is accepted
  always_ff @(posedge sys_clk) begin
    if (rst || state_r == scr_pkg::ST_LOAD) begin
      ov_r <= scr_pkg::DEF_OV; // RL19
    end else if (wr_ov) begin
      ov_r <= req.data; // RL17
    end
  end

  // Strap value caught after reset release, not under reset itself
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      strap_r <= 11'h000;
    end else if (state_r == scr_pkg::ST_LOAD) begin
      strap_r <= rate_strap_khz; // RL12
    end
  end

  // Once the host sets a valid rate the strap no longer decides the frequency
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      override_r <= 1'b0;
    end else if (wr_rate) begin
      override_r <= 1'b1; // RL12
    end
  end

  assign freq_eff = override_r ? rate_r[scr_pkg::MAN_HI:scr_pkg::MAN_LO] : strap_r; // RL2 RL12

  // Read path; unmapped reads answer zero and flag an error
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_data_r <= 16'h0000;
      rd_ack_r <= 1'b0;
    end else begin
      rd_ack_r <= rd_take; // RL21
      if (rd_take) begin
        unique case (req.code)
          scr_pkg::CODE_RATE: rd_data_r <= rate_r; // RL1
          scr_pkg::CODE_START: rd_data_r <= start_r;
          scr_pkg::CODE_STOP: rd_data_r <= stop_r;
          scr_pkg::CODE_MODE: rd_data_r <= mode_r;
          scr_pkg::CODE_OV: rd_data_r <= ov_r;
          scr_pkg::CODE_STATUS: rd_data_r <= {15'h0000, cmd_err_r}; // RL20
          default: rd_data_r <= 16'h0000;
        endcase
      end
    end
  end

  // Sticky command error; a new fault in the clearing cycle still lands
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cmd_err_r <= 1'b0;
    end else if (wr_bad) begin
      cmd_err_r <= 1'b1; // RL4 RL16 RL20
    end else if (rd_bad) begin
      cmd_err_r <= 1'b1; // RL20
    end else if (err_clr) begin
      cmd_err_r <= 1'b0;
    end
  end

  // Hysteresis: start at or above the on level, stop at or below the off level
  always_ff @(posedge sys_clk) begin
    if (rst || !serving) begin
      conv_en_r <= 1'b0;
    end else if (!conv_en_r) begin
      if (vin_half_volts >= start_r[scr_pkg::MAN_HI:scr_pkg::MAN_LO]) begin
        conv_en_r <= 1'b1; // RL6
      end
    end else if (vin_half_volts <= stop_r[scr_pkg::MAN_HI:scr_pkg::MAN_LO]) begin
      conv_en_r <= 1'b0; // RL9
    end
  end

  // Trip comparison, registered so the output is glitch free
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ov_fault_r <= 1'b0;
    end else begin
      ov_fault_r <= serving && (vout_sense > ov_r); // RL17
    end
  end

  // Sync pin: two flops against metastability, the third only for edge finding
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync_s1_r <= 1'b0;
      sync_s2_r <= 1'b0;
      sync_d_r <= 1'b0;
    end else begin
      sync_s1_r <= rate_sync_in;
      sync_s2_r <= sync_s1_r;
      sync_d_r <= sync_s2_r;
    end
  end

  // Supply-good pin passes two flops before anything reads it
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      vdd_s1_r <= 1'b0;
      vdd_s2_r <= 1'b0;
    end else begin
      vdd_s1_r <= vdd_ok_pin;
      vdd_s2_r <= vdd_s1_r;
    end
  end

  // Followers lock only on rising edges; the pin reads our own drive otherwise
  assign ext_edge = mode_follow && sync_s2_r && !sync_d_r; // RL14 RL15

  scr_phase_gen #(
    .ACC_W(scr_pkg::ACC_W),
    .CLK_KHZ(scr_pkg::CLK_KHZ)
  ) u_phase (
    .sys_clk(sys_clk),
    .rst(rst),
    .freq_khz(freq_eff),
    .lock_pulse(ext_edge),
    .lock_anti(mode_r == scr_pkg::MODE_ANTI),
    .pulse_r(gen_pulse)
  );

  // Source mode drives the pin only after the internal supply is good
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync_out_r <= 1'b0;
      sync_oe_r <= 1'b0;
    end else begin
      sync_oe_r <= serving && mode_source && vdd_s2_r; // RL13
      sync_out_r <= serving && mode_source && vdd_s2_r && gen_pulse; // RL13
    end
  end

  // Ports come straight off their flops
  assign rd_data = rd_data_r;
  assign rd_ack = rd_ack_r;
  assign cmd_err = cmd_err_r;
  assign bank_ready = ready_r;
  assign conv_en = conv_en_r;
  assign ov_fault = ov_fault_r;
  assign switch_pulse = gen_pulse;
  assign rate_sync_out = sync_out_r;
  assign rate_sync_oe = sync_oe_r;
endmodule
`default_nettype wire

// ---- design/scr_pkg.sv ----
// Constants, field layouts and carrier types for the switching configuration register bank
// How it works
// RL1: Switching-rate register at code 33h, read/write, value in kilohertz.
// RL2: Rate and threshold words: 5-bit signed exponent over 11-bit signed mantissa.
// RL3: Switching-rate exponent must be zero; host writes it so.
// RL4: Rate writes accepted 300 to 1500 kHz in 50 kHz steps only.
// RL5: Switching-rate register resets to 0258h, 600 kHz.
// RL6: Start threshold at code 35h; conversion begins when input reaches it.
// RL7: Both thresholds use exponent minus one, half-volt mantissa; host writes it.
// RL8: Start threshold accepts 1 to 80 V in 0.5 V steps; default F814h.
// RL9: Stop threshold at code 36h; running converter stops when input falls there.
// RL10: Stop threshold has same range check; default F812h, 9 V.
// RL11: Sync mode at 37h: 0000h solo, 0100h source, 0120h/0121h followers.
// RL12: Base frequency comes from strap until a host rate write overrides it.
// RL13: Source mode drives 50% pulse on sync pin once internal supply good.
// RL14: In-phase follower locks switching to external sync, zero phase offset.
// RL15: Antiphase follower, code 0121h, locks with 180 degree offset.
// RL16: Sync mode defaults 0100h; other codes ignored and reported.
// RL17: Overvoltage trip at 40h, unsigned 16-bit, compared with sensed output.
// RL18: Bit 15 exponent sign, 14:11 exponent, 10 mantissa sign, 9:0 magnitude.
// RL19: Overvoltage trip resets to 0161h, 0.69 V.
// RL20: Rejected write leaves register unchanged, sets readable command-error flag.
// RL21: Registers load nonvolatile defaults before the bank answers any read.
`default_nettype none
package scr_pkg;
  // Command codes
  localparam logic [7:0] CODE_RATE = 8'h33;
  localparam logic [7:0] CODE_START = 8'h35;
  localparam logic [7:0] CODE_STOP = 8'h36;
  localparam logic [7:0] CODE_MODE = 8'h37;
  localparam logic [7:0] CODE_OV = 8'h40;
  localparam logic [7:0] CODE_STATUS = 8'hf0;
  // Nonvolatile defaults
  localparam logic [15:0] DEF_RATE = 16'h0258;
  localparam logic [15:0] DEF_START = 16'hf814;
  localparam logic [15:0] DEF_STOP = 16'hf812;
  localparam logic [15:0] DEF_MODE = 16'h0100;
  localparam logic [15:0] DEF_OV = 16'h0161;
  // Sync mode codes
  localparam logic [15:0] MODE_SOLO = 16'h0000;
  localparam logic [15:0] MODE_SOURCE = 16'h0100;
  localparam logic [15:0] MODE_INPHASE = 16'h0120;
  localparam logic [15:0] MODE_ANTI = 16'h0121;
  // Word layout: exponent 15:11 (sign at 15), mantissa 10:0 (sign at 10)
  localparam int EXP_HI = 15;
  localparam int EXP_LO = 11;
  localparam int MAN_HI = 10;
  localparam int MAN_LO = 0;
  localparam int MAN_W = 11;
  localparam int EXP_W = 5;
  localparam logic [4:0] EXP_RATE = 5'b00000;
  localparam logic [4:0] EXP_VOLT = 5'b11111;
  // Limits
  localparam logic [10:0] RATE_MIN_KHZ = 11'h12c;
  localparam logic [10:0] RATE_MAX_KHZ = 11'h5dc;
  localparam logic [10:0] RATE_STEP_KHZ = 11'h032;
  localparam logic [10:0] VOLT_MIN_HALF = 11'h002;
  localparam logic [10:0] VOLT_MAX_HALF = 11'h0a0;
  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int CLK_KHZ = 1000000 / CLK_PERIOD_NS;
  localparam int ACC_W = 18;

  typedef struct packed {
    logic [7:0] code;
    logic wr;
    logic rd;
    logic [15:0] data;
  } scr_req_t;

  typedef enum logic [1:0] {
    ST_LOAD = 2'b01,
    ST_SERVE = 2'b10
  } scr_state_t;

  // Rate word check: zero exponent, 300..1500 kHz on a 50 kHz grid
  function automatic logic rate_ok(input logic [15:0] w);
    logic [10:0] m;
    m = w[MAN_HI:MAN_LO];
    rate_ok = (w[EXP_HI:EXP_LO] == EXP_RATE) && (m >= RATE_MIN_KHZ) &&
              (m <= RATE_MAX_KHZ) && ((m % RATE_STEP_KHZ) == 11'h000);
  endfunction

  // Threshold word check: exponent minus one, 1..80 V in half volts
  function automatic logic volt_ok(input logic [15:0] w);
    logic [10:0] m;
    m = w[MAN_HI:MAN_LO];
    volt_ok = (w[EXP_HI:EXP_LO] == EXP_VOLT) && (m >= VOLT_MIN_HALF) &&
              (m <= VOLT_MAX_HALF);
  endfunction

  function automatic logic mode_ok(input logic [15:0] w);
    mode_ok = (w == MODE_SOLO) || (w == MODE_SOURCE) || (w == MODE_INPHASE) ||
              (w == MODE_ANTI);
  endfunction
endpackage
`default_nettype wire

// ---- design/scr_phase_gen.sv ----
// Phase accumulator that makes the 50% switching pulse and locks to a sync edge
`timescale 1ns/10ps
`default_nettype none
module scr_phase_gen #(
  parameter int ACC_W = scr_pkg::ACC_W,
  parameter int CLK_KHZ = scr_pkg::CLK_KHZ
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [10:0] freq_khz,
  input wire logic lock_pulse,
  input wire logic lock_anti,
  output logic pulse_r
);
  localparam logic [ACC_W-1:0] WRAP = ACC_W'(CLK_KHZ);
  localparam logic [ACC_W-1:0] HALF = ACC_W'(CLK_KHZ / 2);

  logic [ACC_W-1:0] acc_r;
  logic [ACC_W-1:0] acc_nxt;
  logic [ACC_W-1:0] step;

  // Accumulator advances by the frequency in kHz; a wrap is one switching period
  always_comb begin
    step = acc_r + ACC_W'(freq_khz);
    if (step >= WRAP) begin
      acc_nxt = step - WRAP;
    end else begin
      acc_nxt = step;
    end
  end

  // A sync edge restarts the period at zero or half a turn
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      acc_r <= '0;
    end else if (lock_pulse) begin
      acc_r <= lock_anti ? HALF : '0; // RL14 RL15
    end else begin
      acc_r <= acc_nxt;
    end
  end

  // High for the first half of each turn, giving an even duty cycle
  // A lock lands at the start (high) or the middle (low) of a turn
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pulse_r <= 1'b0;
    end else begin
      pulse_r <= lock_pulse ? !lock_anti : (acc_nxt < HALF); // RL13 RL14 RL15
    end
  end
endmodule
`default_nettype wire

// ---- dv/scr_monitor.sv ----
// Port checker for the switching configuration register bank
`timescale 1ns/10ps
`default_nettype none
module scr_monitor (
  input wire logic sys_clk,
  input wire logic rst,
  input wire scr_pkg::scr_req_t req,
  input wire logic err_clr,
  input wire logic [10:0] rate_strap_khz,
  input wire logic [10:0] vin_half_volts,
  input wire logic [15:0] vout_sense,
  input wire logic vdd_ok_pin,
  input wire logic rate_sync_in,
  input wire logic [15:0] rd_data,
  input wire logic rd_ack,
  input wire logic cmd_err,
  input wire logic bank_ready,
  input wire logic conv_en,
  input wire logic ov_fault,
  input wire logic switch_pulse,
  input wire logic rate_sync_out,
  input wire logic rate_sync_oe
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  logic tw;
  logic tr;
  // Requests the bank really takes; write wins over read
  assign tw = bank_ready && req.wr;
  assign tr = bank_ready && req.rd && !req.wr;
  read_answer_a: assert property (tr |=> rd_ack)
    else $error("read not acknowledged");
  ack_cause_a: assert property (rd_ack |-> $past(tr))
    else $error("acknowledge without a read");
  rate_exp_a: assert property (tw && req.code == 8'h33 && req.data[15:11] != 5'h00 |=> cmd_err)
    else $error("bad rate exponent accepted");
  rate_range_a: assert property (tw && req.code == 8'h33 &&
    (req.data[10:0] < 11'h12c || req.data[10:0] > 11'h5dc) |=> cmd_err)
    else $error("rate outside range accepted");
  volt_exp_a: assert property (tw && req.code inside {8'h35, 8'h36} &&
    req.data[15:11] != 5'h1f |=> cmd_err)
    else $error("bad threshold exponent accepted");
  mode_code_a: assert property (tw && req.code == 8'h37 &&
    !(req.data inside {16'h0000, 16'h0100, 16'h0120, 16'h0121}) |=> cmd_err)
    else $error("undefined mode accepted");
  err_hold_a: assert property (cmd_err && !err_clr |=> cmd_err)
    else $error("error flag dropped by itself");
  err_clear_a: assert property (err_clr && !req.wr && !req.rd |=> !cmd_err)
    else $error("error flag not cleared");
  ready_rise_a: assert property ($fell(rst) |=> bank_ready)
    else $error("bank not ready after load");
  sync_follow_a: assert property (rate_sync_oe && $past(rate_sync_oe) |->
    rate_sync_out == $past(switch_pulse))
    else $error("sync pin not following switching");
endmodule
`default_nettype wire

// ---- dv/scr_host_model.sv ----
// Host controller model issuing register reads and writes
`timescale 1ns/10ps
`default_nettype none
module scr_host_model (
  input wire logic sys_clk,
  input wire logic rd_ack,
  input wire logic [15:0] rd_data,
  output var scr_pkg::scr_req_t req
);
  initial req = '0;
  // Idle lines show the inverse of the last word, so stale data never looks valid
  task automatic put(input logic [7:0] c, input logic w, input logic [15:0] d);
    @(posedge sys_clk);
    #1 req = {c, w, ~w, d};
    @(posedge sys_clk);
    #1 req = {~c, 1'b0, 1'b0, ~d};
  endtask
  // Caller supplies fixed exponents in the word
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    put(c, 1'b1, d);
  endtask
  // Answer stands right after the taking edge, where it is sampled
  task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic a);
    put(c, 1'b0, 16'h0000);
    a = rd_ack;
    d = rd_data;
  endtask
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking bench for the switching configuration register bank
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic sys_clk, rst, err_clr, vdd_ok_pin, rate_sync_in, sync_run, a;
  logic [10:0] rate_strap_khz, vin_half_volts;
  logic [15:0] vout_sense, rd_data, d;
  logic rd_ack, cmd_err, bank_ready, conv_en, ov_fault, switch_pulse;
  logic rate_sync_out, rate_sync_oe;
  scr_pkg::scr_req_t req;
  int error_cnt = 0, num_checks = 0, cyc = 0, k, hi, hs;
  // Code, word, expected read-back, accepted
  logic [43:0] tv [24] = '{44'h33_012c_012c_1, 44'h33_05dc_05dc_1, 44'h33_05de_05dc_0,
    44'h33_0122_05dc_0, 44'h33_0145_05dc_0, 44'h33_0be8_05dc_0, 44'h33_03e8_03e8_1,
    44'h35_f802_f802_1, 44'h35_f801_f802_0, 44'h35_f8a0_f8a0_1, 44'h35_f8a1_f8a0_0,
    44'h35_0814_f8a0_0, 44'h35_f814_f814_1, 44'h36_f802_f802_1, 44'h36_f8a1_f802_0,
    44'h36_f012_f802_0, 44'h36_f812_f812_1, 44'h37_0000_0000_1, 44'h37_0120_0120_1,
    44'h37_0121_0121_1, 44'h37_0101_0121_0, 44'h37_0100_0100_1, 44'h40_ffff_ffff_1,
    44'h40_0200_0200_1};
  scr_top dut (.sys_clk, .rst, .req, .err_clr, .rate_strap_khz, .vin_half_volts,
    .vout_sense, .vdd_ok_pin, .rate_sync_in, .rd_data, .rd_ack, .cmd_err, .bank_ready,
    .conv_en, .ov_fault, .switch_pulse, .rate_sync_out, .rate_sync_oe);
  scr_host_model host (.sys_clk, .rd_ack, .rd_data, .req);
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Neighbour sync at 80 ns, still and low outside bursts
  initial begin
    rate_sync_in = 1'b0;
    #3;
    forever #40 rate_sync_in = sync_run & ~rate_sync_in;
  end
  // Hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic rdchk(input logic [7:0] c, input logic [15:0] exp);
    host.rd(c, d, a);
    chkb(a, 1'b1);
    chk(d, exp);
  endtask
  task automatic clr();
    err_clr = 1'b1;
    step(1);
    err_clr = 1'b0;
  endtask
  task automatic wchk(input logic [7:0] c, input logic [15:0] w, input logic ok,
      input logic [15:0] back);
    host.wr(c, w);
    chkb(cmd_err, ~ok);
    clr();
    rdchk(c, back);
  endtask
  // Counts high cycles of the sync pin and of the switching pulse
  task automatic count(input int n);
    hi = 0;
    hs = 0;
    repeat (n) begin
      step(1);
      hi += rate_sync_out;
      hs += switch_pulse;
    end
  endtask
  task automatic do_reset();
    rst = 1'b1;
    step(2);
    rst = 1'b0;
    k = 0;
    while (bank_ready !== 1'b1 && k < 10) begin
      step(1);
      k++;
    end
    chkb(bank_ready, 1'b1);
  endtask
  initial begin
    rst = 1'b1;
    err_clr = 1'b0;
    vdd_ok_pin = 1'b0;
    sync_run = 1'b0;
    rate_strap_khz = 11'h1f4;
    vin_half_volts = 11'h000;
    vout_sense = 16'h0000;
    do_reset();
    rdchk(8'h33, 16'h0258);
    rdchk(8'h35, 16'hf814);
    rdchk(8'h36, 16'hf812);
    rdchk(8'h37, 16'h0100);
    rdchk(8'h40, 16'h0161);
    rdchk(8'h34, 16'h0000);
    chkb(cmd_err, 1'b1);
    rdchk(8'hf0, 16'h0001);
    clr();
    chkb(rate_sync_oe, 1'b0);
    $display("test defaults done");
    vdd_ok_pin = 1'b1;
    step(6);
    chkb(rate_sync_oe, 1'b1);
    count(400);
    chk(hi[15:0], 16'h00c8);
    $display("test strap rate done");
    for (k = 0; k < 24; k++) begin
      wchk(tv[k][43:36], tv[k][35:20], tv[k][0], tv[k][19:4]);
    end
    $display("test write checks done");
    count(200);
    chk(hi[15:0], 16'h0064);
    vin_half_volts = 11'h014;
    step(1);
    chkb(conv_en, 1'b1);
    vin_half_volts = 11'h013;
    step(1);
    chkb(conv_en, 1'b1);
    vin_half_volts = 11'h012;
    step(1);
    chkb(conv_en, 1'b0);
    vout_sense = 16'h0201;
    step(1);
    chkb(ov_fault, 1'b1);
    vout_sense = 16'h0200;
    step(1);
    chkb(ov_fault, 1'b0);
    $display("test thresholds done");
    sync_run = 1'b1;
    host.wr(8'h37, 16'h0120);
    count(40);
    count(200);
    chk(hs[15:0], 16'h00c8);
    chkb(rate_sync_oe, 1'b0);
    host.wr(8'h37, 16'h0121);
    count(40);
    count(200);
    chk(hs[15:0], 16'h0000);
    sync_run = 1'b0;
    host.wr(8'h37, 16'h0000);
    step(4);
    chkb(rate_sync_oe, 1'b0);
    $display("test sync modes done");
    do_reset();
    rdchk(8'h33, 16'h0258);
    $display("test second reset done");
    end_of_test();
  end
endmodule
bind scr_top scr_monitor mon (.sys_clk, .rst, .req, .err_clr, .rate_strap_khz,
  .vin_half_volts, .vout_sense, .vdd_ok_pin, .rate_sync_in, .rd_data, .rd_ack, .cmd_err,
  .bank_ready, .conv_en, .ov_fault, .switch_pulse, .rate_sync_out, .rate_sync_oe);
`default_nettype wire
